/* hw/tcs_status_regs.sv */
// status register group of a type-c charger detector
//
// Notes on behaviour
// - short flag bit 3 follows vconn current above short threshold.
// - bit 2 shows vconn output enabled.
// - overcurrent flag bit 1 follows vconn current above limit.
// - bit 0 shows cc fsm gating detection; manual run still allowed.
// - attach state bits 6:4 use all eight codes, 101 for the error state.
// - active pin bits 3:2; code 11 never produced.
// - bits 1:0 give allowed sink current code.
// - charger type bits 6:5 report detection result.
// - vendor type bits 4:2; 110 only if option on and dedicated.
// - run bit set while detection runs or has completed.
// - timeout bit 0 set when contact detection times out.
// - a contact timeout does not abort the detection sequence.
// - timeout bit zero when no timeout, or when idle unless a detach met a timeout.
// - ready bit 7 set only after config load and reset release.
// - switch bit 1 zero while open or soft-start, one closed.
// - overvoltage bit 0 follows vbus overvoltage detection.
`timescale 1ns/1ps
module tcs_status_regs
    import tcs_pkg::*;
(
    input  wire logic       mclk,             // 40 MHz system clock
    input  wire logic       rst,              // async reset, active high
    input  wire logic       regRd,            // register read strobe
    input  wire logic       regWr,            // register write strobe (ignored)
    input  wire logic [7:0] regAddr,          // register offset
    input  wire logic [7:0] regWrData,        // write data (ignored)
    output logic      [7:0] regRdData,        // read data, registered
    output logic            regRdValid,       // read data valid pulse
    input  wire logic       shortCmp,         // async vconn short comparator
    input  wire logic       ocCmp,            // async vconn current-limit comparator
    input  wire logic       ovpCmp,           // async vbus overvoltage comparator
    input  wire logic       switchClosedIn,   // async vbus switch fully closed
    input  wire logic       vconnEnable,      // vconn output enable, on-chip
    input  wire logic       ccGatesBc,        // cc fsm gates charger detection
    input  wire logic [2:0] ccState,          // cc fsm attach code
    input  wire logic       ccError,          // cc fsm in error state
    input  wire logic [1:0] ccPin,            // active cc pin code
    input  wire logic [1:0] sinkCurrent,      // advertised sink current code
    input  wire logic       autoDetectStart,  // automatic detection request pulse
    input  wire logic       manualDetect,     // manual detection request pulse
    input  wire logic       detectDone,       // detection finished pulse
    input  wire logic       detectClear,      // detach, resets detection pulse
    input  wire logic       dcdTimeoutEvt,    // contact detection timeout pulse
    input  wire logic [1:0] chargerTypeIn,    // detection result code
    input  wire logic [2:0] vendorTypeIn,     // proprietary detection code
    input  wire logic       highCurrentEn,    // option: allow 3 A dedicated code
    input  wire logic       otpLoaded,        // configuration load finished
    output logic            detectActive      // detection sequence running
);
    // ------------------------------------------------------------
    // input synchronisation
    // ------------------------------------------------------------
    logic [3:0] cmpSync;
    logic       shortFlag;
    logic       ocFlag;
    logic       ovpFlag;
    logic       switchClosed;

    // comparator outputs are analog and not on mclk
    tcs_sync3 #(.W(4)) uSync (
        .mclk (mclk),
        .rst  (rst),
        .din  ({switchClosedIn, ovpCmp, ocCmp, shortCmp}),
        .dout (cmpSync)
    );

    assign shortFlag    = cmpSync[0];
    assign ocFlag       = cmpSync[1];
    assign ovpFlag      = cmpSync[2];
    assign switchClosed = cmpSync[3];

    // ------------------------------------------------------------
    // charger detection run tracking
    // ------------------------------------------------------------
    tcs_det_state_t detState_r;
    tcs_det_state_t detState_nxt;
    logic           startReq;
    logic           dcdTimeout_r;
    logic           configReady_r;

    assign startReq = (autoDetectStart && !ccGatesBc) || manualDetect;

    // timeout keeps run going; only done or detach end it
    always_comb begin
        detState_nxt = detState_r;
        unique case (detState_r)
            DET_IDLE: if (startReq) detState_nxt = DET_RUN;
            DET_RUN: begin
                if (detectClear) detState_nxt = DET_IDLE;
                else if (detectDone) detState_nxt = DET_DONE;
            end
            DET_DONE: begin
                if (detectClear) detState_nxt = DET_IDLE;
                else if (startReq) detState_nxt = DET_RUN;
            end
            default: detState_nxt = DET_IDLE;
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            detState_r <= DET_IDLE;
        end else begin
            detState_r <= detState_nxt;
        end
    end

    assign detectActive = (detState_r == DET_RUN);

    // timeout flag capture
    // a fresh run or a detach clears it, except a detach in the same cycle as a timeout in a run
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            dcdTimeout_r <= 1'b0;
        end else if (detState_r == DET_RUN && dcdTimeoutEvt) begin
            dcdTimeout_r <= 1'b1;
        end else if (detectClear || (detState_r != DET_RUN && startReq)) begin
            dcdTimeout_r <= 1'b0;
        end
    end

    // ready follows load after reset release
    // sampled by a clock so reset never loads a port value
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            configReady_r <= 1'b0;
        end else begin
            configReady_r <= otpLoaded;
        end
    end

    // ------------------------------------------------------------
    // field encoding
    // ------------------------------------------------------------
    logic [2:0] attachCode;
    logic [1:0] pinCode;
    logic [1:0] chgCode;
    logic [2:0] vendCode;

    assign attachCode = ccError ? CC_ERROR_CODE : ccState;

    assign pinCode = (ccPin == PIN_RESERVED) ? PIN_UNDETERMINED : ccPin;

    // result only once a run happened
    assign chgCode = (detState_r == DET_IDLE) ? CHG_NONE : chargerTypeIn;

    // guard high current code
    // without the option, or with no dedicated result shown, it degrades to unidentified
    always_comb begin
        vendCode = vendorTypeIn;
        if (vendorTypeIn == VEND_HIGH_CURRENT &&
            !(highCurrentEn && chgCode == CHG_DEDICATED)) begin
            vendCode = VEND_UNIDENTIFIED;
        end
    end

    // ------------------------------------------------------------
    // register images
    // ------------------------------------------------------------
    logic [7:0] supply_r;
    logic [7:0] attach_r;
    logic [7:0] detect_r;
    logic [7:0] protect_r;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            supply_r <= STATUS_RESET;
        end else begin
            supply_r                  <= STATUS_RESET;
            supply_r[BIT_SHORT_FLAG]  <= shortFlag;
            supply_r[BIT_OUTPUT_ON]   <= vconnEnable;
            supply_r[BIT_OVERCURRENT] <= ocFlag;
            supply_r[BIT_BC_GATED]    <= ccGatesBc;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            attach_r <= STATUS_RESET;
        end else begin
            attach_r                                      <= STATUS_RESET;
            attach_r[LSB_ATTACH_STATE +: 3]               <= attachCode;
            attach_r[LSB_ACTIVE_PIN +: 2]                 <= pinCode;
            attach_r[LSB_SINK_CURRENT +: 2]               <= sinkCurrent;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            detect_r <= STATUS_RESET;
        end else begin
            detect_r                        <= STATUS_RESET;
            detect_r[LSB_CHARGER_TYPE +: 2] <= chgCode;
            detect_r[LSB_VENDOR_TYPE +: 3]  <= vendCode;
            detect_r[BIT_DETECT_RUN]        <= (detState_r != DET_IDLE);
            detect_r[BIT_DCD_TIMEOUT]       <= dcdTimeout_r;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            protect_r <= STATUS_RESET;
        end else begin
            protect_r                   <= STATUS_RESET;
            protect_r[BIT_CONFIG_DONE]  <= configReady_r;
            protect_r[BIT_SWITCH_CLOSE] <= switchClosed;
            protect_r[BIT_VBUS_OVP]     <= ovpFlag;
        end
    end

    // ------------------------------------------------------------
    // register read port
    // ------------------------------------------------------------
    // writes never reach the images
    // regWr and regWrData are deliberately left without effect
    tcs_reg_port uPort (
        .mclk        (mclk),
        .rst         (rst),
        .regRd       (regRd),
        .regAddr     (regAddr),
        .supplyByte  (supply_r),
        .attachByte  (attach_r),
        .detectByte  (detect_r),
        .protectByte (protect_r),
        .regRdData   (regRdData),
        .regRdValid  (regRdValid)
    );

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence s_runStart;
        detState_r == DET_IDLE && startReq;
    endsequence

    sequence s_runBitUp;
        ##1 detState_r == DET_RUN ##1 detect_r[BIT_DETECT_RUN];
    endsequence

    property p_shortFlag;
        shortFlag |=> supply_r[BIT_SHORT_FLAG];
    endproperty
    a_shortFlag: assert property (p_shortFlag)
        else $error("short flag not reported");
    property p_outputOn;
        $rose(vconnEnable) |=> supply_r[BIT_OUTPUT_ON];
    endproperty
    a_outputOn: assert property (p_outputOn)
        else $error("vconn enable not reported");
    property p_overcurrent;
        !ocFlag |=> !supply_r[BIT_OVERCURRENT];
    endproperty
    a_overcurrent: assert property (p_overcurrent)
        else $error("overcurrent flag stuck");
    property p_gatedStart;
        detState_r == DET_IDLE && ccGatesBc && autoDetectStart && !manualDetect
            |=> detState_r == DET_IDLE;
    endproperty
    a_gatedStart: assert property (p_gatedStart)
        else $error("gated detection started");
    property p_errorCode;
        ccError |=> attach_r[LSB_ATTACH_STATE +: 3] == CC_ERROR_CODE;
    endproperty
    a_errorCode: assert property (p_errorCode)
        else $error("error state code wrong");
    property p_pinReserved;
        attach_r[LSB_ACTIVE_PIN +: 2] != PIN_RESERVED;
    endproperty
    a_pinReserved: assert property (p_pinReserved)
        else $error("reserved pin code produced");
    property p_vendorGuard;
        detect_r[LSB_VENDOR_TYPE +: 3] == VEND_HIGH_CURRENT
            |-> detect_r[LSB_CHARGER_TYPE +: 2] == CHG_DEDICATED && $past(highCurrentEn);
    endproperty
    a_vendorGuard: assert property (p_vendorGuard)
        else $error("high current code without option");
    property p_runBit;
        s_runStart and !detectClear |-> s_runBitUp;
    endproperty
    a_runBit: assert property (p_runBit)
        else $error("run bit not set after start");
    property p_timeoutSet;
        detState_r == DET_RUN && dcdTimeoutEvt ##1 1 |=> detect_r[BIT_DCD_TIMEOUT];
    endproperty
    a_timeoutSet: assert property (p_timeoutSet)
        else $error("timeout not reported");
    property p_timeoutNoAbort;
        detState_r == DET_RUN && dcdTimeoutEvt && !detectDone && !detectClear
            |=> detState_r == DET_RUN;
    endproperty
    a_timeoutNoAbort: assert property (p_timeoutNoAbort)
        else $error("timeout aborted detection");
    // a detach meeting a timeout keeps the flag, because the set wins
    property p_timeoutIdle;
        (detState_r == DET_IDLE && !dcdTimeout_r) || (detectClear && !dcdTimeoutEvt)
            |=> !dcdTimeout_r;
    endproperty
    a_timeoutIdle: assert property (p_timeoutIdle)
        else $error("timeout shown without a run");
    property p_readyLoad;
        !otpLoaded [*2] |=> !protect_r[BIT_CONFIG_DONE];
    endproperty
    a_readyLoad: assert property (p_readyLoad)
        else $error("ready before configuration load");
    property p_ovp;
        ovpFlag |=> protect_r[BIT_VBUS_OVP];
    endproperty
    a_ovp: assert property (p_ovp)
        else $error("overvoltage not reported");
    property p_unused;
        supply_r[7:4] == 4'h0 && attach_r[7] == 1'b0 && detect_r[7] == 1'b0 &&
            protect_r[6:2] == 5'h00;
    endproperty
    a_unused: assert property (p_unused)
        else $error("unused bit reads non-zero");
endmodule : tcs_status_regs

/* hw/tcs_pkg.sv */
// constants shared by the type-c charger status register group
package tcs_pkg;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CC_SUPPLY_STATUS      = 8'h08;
    localparam logic [7:0] OFS_CC_ATTACH_STATUS      = 8'h09;
    localparam logic [7:0] OFS_CHARGER_DETECT_STATUS = 8'h0A;
    localparam logic [7:0] OFS_VBUS_PROTECT_STATUS   = 8'h0B;
    localparam logic [7:0] STATUS_RESET              = 8'h00;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int BIT_SHORT_FLAG   = 3;
    localparam int BIT_OUTPUT_ON    = 2;
    localparam int BIT_OVERCURRENT  = 1;
    localparam int BIT_BC_GATED     = 0;
    localparam int LSB_ATTACH_STATE = 4;
    localparam int LSB_ACTIVE_PIN   = 2;
    localparam int LSB_SINK_CURRENT = 0;
    localparam int LSB_CHARGER_TYPE = 5;
    localparam int LSB_VENDOR_TYPE  = 2;
    localparam int BIT_DETECT_RUN   = 1;
    localparam int BIT_DCD_TIMEOUT  = 0;
    localparam int BIT_CONFIG_DONE  = 7;
    localparam int BIT_SWITCH_CLOSE = 1;
    localparam int BIT_VBUS_OVP     = 0;

    // ------------------------------------------------------------
    // field encodings
    // ------------------------------------------------------------
    localparam logic [2:0] CC_ERROR_CODE     = 3'h5;
    localparam logic [1:0] PIN_UNDETERMINED  = 2'h0;
    localparam logic [1:0] PIN_RESERVED      = 2'h3;
    localparam logic [1:0] CHG_NONE          = 2'h0;
    localparam logic [1:0] CHG_DEDICATED     = 2'h3;
    localparam logic [2:0] VEND_HIGH_CURRENT = 3'h6;
    localparam logic [2:0] VEND_UNIDENTIFIED = 3'h7;

    // charger detection run tracker
    typedef enum logic [2:0] {
        DET_IDLE = 3'b001,
        DET_RUN  = 3'b010,
        DET_DONE = 3'b100
    } tcs_det_state_t;
endpackage : tcs_pkg

/* hw/tcs_sync3.sv */
// three-stage synchroniser for asynchronous status levels
`timescale 1ns/1ps
module tcs_sync3 #(
    parameter int W = 1
) (
    input  wire logic         mclk,  // system clock
    input  wire logic         rst,   // async reset, active high
    input  wire logic [W-1:0] din,   // asynchronous levels
    output logic      [W-1:0] dout   // filtered, synchronous levels
);
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
    logic [W-1:0] stage3;

    // stage1 feeds only stage2 to keep metastability contained
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
        end else begin
            stage1 <= din;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // a change counts only once the last two stages agree
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            dout <= '0;
        end else begin
            for (int i = 0; i < W; i++) begin
                if (stage2[i] == stage3[i]) begin
                    dout[i] <= stage3[i];
                end
            end
        end
    end
endmodule : tcs_sync3

/* hw/tcs_reg_port.sv */
// read port that serves the four status registers
`timescale 1ns/1ps
module tcs_reg_port
    import tcs_pkg::*;
(
    input  wire logic       mclk,        // system clock
    input  wire logic       rst,         // async reset, active high
    input  wire logic       regRd,       // read strobe, one cycle
    input  wire logic [7:0] regAddr,     // register offset
    input  wire logic [7:0] supplyByte,  // cc_supply_status contents
    input  wire logic [7:0] attachByte,  // cc_attach_status contents
    input  wire logic [7:0] detectByte,  // charger_detect_status contents
    input  wire logic [7:0] protectByte, // vbus_protect_status contents
    output logic      [7:0] regRdData,   // read data, registered
    output logic            regRdValid   // read data valid, one cycle
);
    logic [7:0] muxData;

    // unmapped offsets read as zero
    always_comb begin
        unique case (regAddr)
            OFS_CC_SUPPLY_STATUS:      muxData = supplyByte;
            OFS_CC_ATTACH_STATUS:      muxData = attachByte;
            OFS_CHARGER_DETECT_STATUS: muxData = detectByte;
            OFS_VBUS_PROTECT_STATUS:   muxData = protectByte;
            default:                   muxData = STATUS_RESET;
        endcase
    end

    // data holds until the next read
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            regRdData <= STATUS_RESET;
        end else if (regRd) begin
            regRdData <= muxData;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            regRdValid <= 1'b0;
        end else begin
            regRdValid <= regRd;
        end
    end
endmodule : tcs_reg_port

/* verification/tb_top.sv */
// self-checking bench for the type-c charger status register group
`timescale 1ns/1ps
module tb_top
    import tcs_pkg::*;
;

    // ------------------------------------------------------------
    // design connections
    // ------------------------------------------------------------
    logic       mclk, rst, regRd, regWr, regRdValid, detectActive;
    logic [7:0] regAddr, regWrData, regRdData;
    logic       shortCmp, ocCmp, ovpCmp, switchClosedIn, vconnEnable, ccGatesBc, ccError;
    logic [2:0] ccState, vendorTypeIn;
    logic [1:0] ccPin, sinkCurrent, chargerTypeIn;
    logic       autoDetectStart, manualDetect, detectDone, detectClear, dcdTimeoutEvt;
    logic       highCurrentEn, otpLoaded;
    int         num_errors, comparisons;

    // one row: cc inputs beside the bytes expected at 0x09 and 0x08
    typedef struct packed {
        logic [2:0] st;
        logic       err;
        logic [1:0] pin;
        logic [1:0] cur;
        logic       ven;
        logic       gate;
        logic [7:0] exp09;
        logic [7:0] exp08;
    } tcs_row_t;

    tcs_row_t rows [8] = '{
        '{3'h0, 1'b0, 2'h0, 2'h0, 1'b0, 1'b0, 8'h00, 8'h00},
        '{3'h1, 1'b0, 2'h1, 2'h1, 1'b1, 1'b0, 8'h15, 8'h04},
        '{3'h2, 1'b0, 2'h2, 2'h2, 1'b0, 1'b1, 8'h2A, 8'h01},
        '{3'h3, 1'b0, 2'h1, 2'h3, 1'b1, 1'b1, 8'h37, 8'h05},
        '{3'h4, 1'b0, 2'h2, 2'h0, 1'b0, 1'b0, 8'h48, 8'h00},
        '{3'h6, 1'b0, 2'h0, 2'h0, 1'b0, 1'b0, 8'h60, 8'h00},
        '{3'h7, 1'b0, 2'h1, 2'h1, 1'b0, 1'b0, 8'h75, 8'h00},
        '{3'h1, 1'b1, 2'h3, 2'h2, 1'b0, 1'b0, 8'h52, 8'h00}
    };

    tcs_status_regs tcs_status_regs_inst (
        .mclk(mclk), .rst(rst), .regRd(regRd), .regWr(regWr), .regAddr(regAddr),
        .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid),
        .shortCmp(shortCmp), .ocCmp(ocCmp), .ovpCmp(ovpCmp),
        .switchClosedIn(switchClosedIn), .vconnEnable(vconnEnable), .ccGatesBc(ccGatesBc),
        .ccState(ccState), .ccError(ccError), .ccPin(ccPin), .sinkCurrent(sinkCurrent),
        .autoDetectStart(autoDetectStart), .manualDetect(manualDetect),
        .detectDone(detectDone), .detectClear(detectClear), .dcdTimeoutEvt(dcdTimeoutEvt),
        .chargerTypeIn(chargerTypeIn), .vendorTypeIn(vendorTypeIn),
        .highCurrentEn(highCurrentEn), .otpLoaded(otpLoaded), .detectActive(detectActive)
    );

    // ------------------------------------------------------------
    // clock and watchdog
    // ------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    // the whole run needs well under 1000 cycles, so 5000 means a hang
    initial begin
        #(25 * 5000);
        num_errors++;
        test_done();
    end

    // ------------------------------------------------------------
    // compare and bus tasks
    // ------------------------------------------------------------
    task automatic checkByte(input string n, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : checkByte

    task automatic checkBit(input string n, input logic e, input logic g);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %s expected %b seen %b", n, e, g);
        end
    endtask : checkBit

    // read strobe for one cycle; data arrives with the valid pulse one edge later
    // sampled mid-cycle, then hands back on a rising edge so callers drive there
    task automatic expReg(input string n, input logic [7:0] a, m, e);
        @(posedge mclk);
        regRd   <= 1'b1;
        regAddr <= a;
        @(posedge mclk);
        regRd <= 1'b0;
        @(negedge mclk);
        checkBit("regRdValid", 1'b1, regRdValid);
        checkByte(n, e, regRdData & m);
        @(posedge mclk);
    endtask : expReg

    // a write must leave every status byte untouched
    task automatic writeReg(input logic [7:0] a, d);
        @(posedge mclk);
        regWr     <= 1'b1;
        regAddr   <= a;
        regWrData <= d;
        @(posedge mclk);
        regWr <= 1'b0;
    endtask : writeReg

    // one-cycle request pulse: 0 manual, 1 auto, 2 done, 3 clear, 4 timeout
    task automatic pulse(input int k);
        @(posedge mclk);
        case (k)
            0: manualDetect <= 1'b1;
            1: autoDetectStart <= 1'b1;
            2: detectDone <= 1'b1;
            3: detectClear <= 1'b1;
            default: dcdTimeoutEvt <= 1'b1;
        endcase
        @(posedge mclk);
        {manualDetect, autoDetectStart, detectDone, detectClear, dcdTimeoutEvt} <= 5'h00;
        @(negedge mclk);
    endtask : pulse

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : test_done

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {rst, regRd, regWr, regAddr, regWrData} = {1'b1, 1'b0, 1'b0, 8'h00, 8'h00};
        {shortCmp, ocCmp, ovpCmp, switchClosedIn, vconnEnable, ccGatesBc, ccError} = 7'h00;
        {ccState, vendorTypeIn, ccPin, sinkCurrent, chargerTypeIn} = 12'h000;
        {autoDetectStart, manualDetect, detectDone, detectClear, dcdTimeoutEvt} = 5'h00;
        {highCurrentEn, otpLoaded} = 2'h0;
        num_errors  = 0;
        comparisons = 0;
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        // reset values, ready bit low until the configuration load ends
        for (int a = 8; a < 12; a++) begin
            expReg("reset value", a[7:0], 8'hFF, STATUS_RESET);
        end
        otpLoaded <= 1'b1;
        repeat (2) @(posedge mclk);
        expReg("config_load_done", OFS_VBUS_PROTECT_STATUS, 8'hFF, 8'h80);
        $display("test reset done");

        // cc attach table: every attach code, pin code and current code
        foreach (rows[i]) begin
            @(posedge mclk);
            {ccState, ccError, ccPin, sinkCurrent} <= {rows[i].st, rows[i].err, rows[i].pin,
                                                      rows[i].cur};
            {vconnEnable, ccGatesBc} <= {rows[i].ven, rows[i].gate};
            repeat (2) @(posedge mclk);
            expReg("cc_attach_status", OFS_CC_ATTACH_STATUS, 8'hFF, rows[i].exp09);
            expReg("cc_supply_status", OFS_CC_SUPPLY_STATUS, 8'hFF, rows[i].exp08);
        end
        $display("test cc table done");

        // comparator levels pass the synchroniser into their bits
        for (int i = 0; i < 4; i++) begin
            @(posedge mclk);
            {shortCmp, switchClosedIn, ocCmp, ovpCmp} <= {i[0], i[0], i[1], i[1]};
            repeat (8) @(posedge mclk);
            expReg("supply flags", OFS_CC_SUPPLY_STATUS, 8'h0A,
                   {4'h0, i[0], 1'b0, i[1], 1'b0});
            expReg("vbus flags", OFS_VBUS_PROTECT_STATUS, 8'h03, {6'h00, i[0], i[1]});
        end
        $display("test comparators done");

        // detection tracker, awkward orders first
        {chargerTypeIn, vendorTypeIn} <= {CHG_DEDICATED, VEND_HIGH_CURRENT};
        pulse(4);
        expReg("idle detect", OFS_CHARGER_DETECT_STATUS, 8'h63, 8'h00);
        ccGatesBc <= 1'b1;
        pulse(1);
        checkBit("detectActive", 1'b0, detectActive);
        expReg("bc_gated_by_cc", OFS_CC_SUPPLY_STATUS, 8'h01, 8'h01);
        pulse(0);
        checkBit("detectActive", 1'b1, detectActive);
        expReg("charger_detect_running", OFS_CHARGER_DETECT_STATUS, 8'h03, 8'h02);
        pulse(4);
        checkBit("detectActive", 1'b1, detectActive);
        expReg("timeout result", OFS_CHARGER_DETECT_STATUS, 8'hFF, 8'h7F);
        highCurrentEn <= 1'b1;
        repeat (2) @(posedge mclk);
        expReg("vendor_charger_type", OFS_CHARGER_DETECT_STATUS, 8'h1C, 8'h18);
        pulse(2);
        checkBit("detectActive", 1'b0, detectActive);
        expReg("run after done", OFS_CHARGER_DETECT_STATUS, 8'h02, 8'h02);
        writeReg(OFS_CHARGER_DETECT_STATUS, 8'h00);
        expReg("after write", OFS_CHARGER_DETECT_STATUS, 8'hFF, 8'h7B);
        pulse(3);
        expReg("after detach", OFS_CHARGER_DETECT_STATUS, 8'hFF, 8'h1C);
        ccGatesBc <= 1'b0;
        pulse(1);
        checkBit("detectActive", 1'b1, detectActive);
        pulse(3);
        $display("test detection done");

        // unmapped offsets read zero
        expReg("unmapped 0x07", 8'h07, 8'hFF, 8'h00);
        expReg("unmapped 0x0C", 8'h0C, 8'hFF, 8'h00);
        $display("test unmapped done");
        test_done();
    end
endmodule : tb_top
